// ===== rtl/mfr_command_logging_bank.sv
// Manufacturer command bank: ROM entry, current share, ramp recorder, sensor select, trims, status log
`timescale 1ns/1ns
`include "mfr_consts.svh"

module mfr_command_logging_bank
   import mfr_pkg::*;
#(
   parameter logic [31:0] LOG_INTERVAL_CYCLES = `LOG_INTERVAL_CYCLES  // Cycles between status captures
) (
   input  wire logic         core_clk,        // 50 MHz clock
   input  wire logic         rst,             // Synchronous reset, high
   input  wire logic         ce,              // Clock enable, freezes all state when low
   input  wire logic         cmd_valid,       // Decoded command present, one cycle
   input  wire logic         cmd_write,       // 1 write, 0 read
   input  wire logic [7:0]   cmd_code,        // Command code
   input  wire logic [5:0]   wr_len,          // Write byte count
   input  wire logic [255:0] wr_data,         // Write payload, byte 0 in bits 7:0
   input  wire logic         ramp_active,     // Output ramp in progress
   input  wire logic         ramp_ok,         // Ramp-up completed successfully, pulse
   input  wire logic [31:0]  ramp_cycles,     // Configured ramp duration in cycles
   input  wire logic [15:0]  snapshot_count,  // Last snapshot-cycle count
   input  wire logic [7:0]   vin_sample,      // Instant input voltage
   input  wire logic [7:0]   vout_sample,     // Instant output voltage
   input  wire logic [15:0]  status_word,     // Live status word
   input  wire logic [15:0]  temp_internal,   // On-chip temperature reading
   input  wire logic [15:0]  temp_external,   // Remote temperature reading
   input  wire logic [15:0]  vin_on_offset,   // Trimmed turn-on offset
   input  wire logic [15:0]  vin_off_offset,  // Trimmed turn-off offset
   input  wire logic [15:0]  vout_trim,       // Signed output trim
   output logic              rd_valid,        // Read answer present
   output logic [5:0]        rd_len,          // Read answer byte count
   output logic [255:0]      rd_data,         // Read answer payload
   output logic              cmd_error,       // Command refused
   output logic              rom_mode,        // Controller in ROM mode
   output logic [47:0]       share_threshold, // Current share threshold
   output logic              share_enable,    // Active current share on
   output logic [15:0]       temp_primary,    // Selected sensor reading
   output logic [15:0]       temp_secondary   // Non-selected sensor reading
);

   // Decode of the incoming command
   wire is_rom    = (cmd_code == `CMD_ROM_MODE);
   wire is_thr    = (cmd_code == `CMD_SHARE_THRESHOLD);
   wire is_ramp   = (cmd_code == `CMD_RAMP_RECORD);
   wire is_sel    = (cmd_code == `CMD_TEMP_SELECT);
   wire is_vin    = (cmd_code == `CMD_VIN_OFFSETS);
   wire is_vout   = (cmd_code == `CMD_VOUT_TRIM);
   wire is_status = (cmd_code == `CMD_STATUS_LOG);
   wire wr_cmd    = cmd_valid & cmd_write;
   wire rd_cmd    = cmd_valid & ~cmd_write;
   // Plain ASCII has bit 7 clear in every byte
   wire rom_ascii = ~|{wr_data[31], wr_data[23], wr_data[15], wr_data[7]};
   wire wr_rom_ok = wr_cmd & is_rom & (wr_len == `LEN_ROM_MODE) & rom_ascii;
   wire wr_thr_ok = wr_cmd & is_thr & (wr_len == `LEN_SHARE_THRESHOLD);
   wire wr_sel_ok = wr_cmd & is_sel & (wr_len == `LEN_TEMP_SELECT);
   wire rd_ok     = rd_cmd & (is_thr | is_ramp | is_sel | is_vin | is_vout | is_status);
   wire cmd_bad   = cmd_valid & ~(wr_rom_ok | wr_thr_ok | wr_sel_ok | rd_ok);

   // Control registers
   logic          temp_select;             // 0 internal, 1 external
   logic          ramp_prev;               // Ramp level one cycle ago
   ramp_state_type ramp_state;             // Ramp recorder state
   logic [3:0]    ramp_idx;                // Next sample pair slot
   logic [32:0]   ramp_acc;                // Sample spacing accumulator
   logic [15:0]   ramp_counter;            // Counter stored before ramp
   log_state_type log_state;               // Status logger state
   logic [3:0]    log_slot;                // Next status slot
   logic [31:0]   log_timer;               // Cycles since last capture

   // Sample memories
   byte_type      vin_mem  [`RAMP_PAIRS];  // Input voltage samples
   byte_type      vout_mem [`RAMP_PAIRS];  // Output voltage samples
   word_type      log_mem  [`LOG_WORDS];   // Logged status words
   logic [255:0]  ramp_pack;               // Packed ramp block
   logic [255:0]  log_pack;                // Packed status block

   // Edges of the ramp level
   wire ramp_rise = ramp_active & ~ramp_prev;
   wire ramp_fall = ~ramp_active & ramp_prev;

   // Spacing: add 15 each cycle, sample each time the configured duration is crossed
   wire [32:0] acc_sum   = ramp_acc + 33'(`RAMP_PAIRS);
   wire        acc_cross = (acc_sum >= {1'b0, ramp_cycles});
   wire        ramp_take = (ramp_state == RAMP_REC) & acc_cross & ~ramp_ok;
   wire        ramp_last = ramp_take & (ramp_idx == 4'(`RAMP_PAIRS - 1));
   wire [32:0] next_acc  = acc_cross ? (acc_sum - {1'b0, ramp_cycles}) : acc_sum;

   // Status capture at the end of the first ramp, then once per interval
   wire log_start = (log_state == LOG_IDLE) & ramp_fall;
   wire log_tick  = (log_state == LOG_RUN) & (log_timer == (LOG_INTERVAL_CYCLES - 32'h1));
   wire log_take  = log_start | log_tick;
   wire log_last  = log_take & (log_slot == 4'(`LOG_WORDS - 1));

   // Read answer selection
   wire [63:0] thr_read = {7'h00, share_enable, 8'h00, share_threshold};
   wire [5:0] next_rd_len =
      is_thr    ? `LEN_SHARE_THRESHOLD :
      is_ramp   ? `LEN_RAMP_RECORD     :
      is_sel    ? `LEN_TEMP_SELECT     :
      is_vin    ? `LEN_VIN_OFFSETS     :
      is_vout   ? `LEN_VOUT_TRIM       :
                  `LEN_STATUS_LOG;
   wire [255:0] next_rd_data =
      is_thr    ? {192'h0, thr_read}                       :
      is_ramp   ? ramp_pack                                :
      is_sel    ? {255'h0, temp_select}                    :
      is_vin    ? {224'h0, vin_on_offset, vin_off_offset}  :
      is_vout   ? {240'h0, vout_trim}                      :
                  log_pack;

   assign temp_primary   = temp_select ? temp_external : temp_internal;
   assign temp_secondary = temp_select ? temp_internal : temp_external;

   // Read answer and refusal flags
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_valid  <= 1'b0;
         rd_len    <= 6'h00;
         rd_data   <= 256'h0;
         cmd_error <= 1'b0;
      end else if (ce) begin
         rd_valid  <= rd_ok;
         cmd_error <= cmd_bad;
         if (rd_ok) begin
            rd_len  <= next_rd_len;
            rd_data <= next_rd_data;
         end
      end
   end

   // ROM entry latch, held until reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rom_mode <= 1'b0;
      end else if (ce && wr_rom_ok) begin
         rom_mode <= 1'b1;
      end
   end

   // threshold and enable, other bits dropped
   always_ff @(posedge core_clk) begin
      if (rst) begin
         share_threshold <= `THR_RESET;
         share_enable    <= 1'b0;
      end else if (ce && wr_thr_ok) begin
         share_threshold <= wr_data[`THR_MSB:0];
         share_enable    <= wr_data[`THR_ENABLE_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         temp_select <= `SEL_RESET;
      end else if (ce && wr_sel_ok) begin
         temp_select <= wr_data[`SEL_SOURCE_BIT];
      end
   end

   // Ramp level history
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ramp_prev <= 1'b0;
      end else if (ce) begin
         ramp_prev <= ramp_active;
      end
   end

   // Ramp recorder sequence
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ramp_state   <= RAMP_WAIT;
         ramp_idx     <= 4'h0;
         ramp_acc     <= 33'h0;
         ramp_counter <= 16'h0000;
      end else if (ce) begin
         unique case (ramp_state)
            RAMP_WAIT: begin
               if (ramp_rise) begin
                  ramp_state   <= RAMP_REC;
                  ramp_counter <= snapshot_count + 16'h0001;
                  ramp_idx     <= 4'h0;
                  ramp_acc     <= 33'h0;
               end
            end
            RAMP_REC: begin
               ramp_acc <= next_acc;
               if (ramp_take) begin
                  ramp_idx <= ramp_idx + 4'h1;
               end
               if (ramp_last || ramp_fall) begin
                  ramp_state <= RAMP_HELD;
               end
            end
            RAMP_HELD: begin
               ramp_state <= RAMP_HELD;
            end
            default: begin
               ramp_state <= RAMP_WAIT;
            end
         endcase
         if (ramp_ok) begin
            ramp_counter <= 16'h0000;
         end
      end
   end

   // Status logger sequence
   always_ff @(posedge core_clk) begin
      if (rst) begin
         log_state <= LOG_IDLE;
         log_slot  <= 4'h0;
         log_timer <= 32'h0;
      end else if (ce) begin
         unique case (log_state)
            LOG_IDLE: begin
               if (log_start) begin
                  log_state <= LOG_RUN;
                  log_slot  <= 4'h1;
                  log_timer <= 32'h0;
               end
            end
            LOG_RUN: begin
               log_timer <= log_tick ? 32'h0 : log_timer + 32'h1;
               if (log_take) begin
                  log_slot <= log_slot + 4'h1;
               end
               if (log_last) begin
                  log_state <= LOG_DONE;
               end
            end
            LOG_DONE: begin
               log_state <= LOG_DONE;
            end
            default: begin
               log_state <= LOG_IDLE;
            end
         endcase
      end
   end

   // Per-entry storage and packing of both blocks
   for (genvar k = 0; k < `LOG_WORDS; k++) begin : g_entry
      always_ff @(posedge core_clk) begin
         if (rst) begin
            log_mem[k] <= 16'h0000;
         end else if (ce && log_take && (log_slot == 4'(k))) begin
            log_mem[k] <= status_word;
         end
      end
      assign log_pack[16*k +: 16] = log_mem[k];
      if (k < `RAMP_PAIRS) begin : g_pair
         always_ff @(posedge core_clk) begin
            if (rst || (ce && ramp_ok)) begin
               vin_mem[k]  <= 8'h00;
               vout_mem[k] <= 8'h00;
            end else if (ce && ramp_take && (ramp_idx == 4'(k))) begin
               vin_mem[k]  <= vin_sample;
               vout_mem[k] <= vout_sample;
            end
         end
         assign ramp_pack[16*k + 16 +: 16] = {vout_mem[k], vin_mem[k]};
      end
   end
   assign ramp_pack[15:0] = ramp_counter;

   // Checks
   sequence seq_first_fall;
      ce && log_state == LOG_IDLE && ramp_fall;
   endsequence
   sequence seq_log_armed;
      log_state == LOG_RUN && log_slot == 4'h1 && log_mem[0] == $past(status_word);
   endsequence

   AST_ROM_ENTRY: assert property (@(posedge core_clk) disable iff (rst)
      (ce && wr_rom_ok) |=> rom_mode [*3]) else $error("ROM mode not entered");
   AST_THR_STORE: assert property (@(posedge core_clk) disable iff (rst)
      (ce && wr_thr_ok) |=> share_threshold == $past(wr_data[47:0])) else $error("threshold not stored");
   AST_SHARE_EN: assert property (@(posedge core_clk) disable iff (rst)
      (ce && wr_thr_ok) |=> share_enable == $past(wr_data[56])) else $error("share enable wrong");
   AST_THR_ZERO: assert property (@(posedge core_clk) disable iff (rst)
      (ce && rd_ok && is_thr) |=> rd_valid && rd_data[63:57] == 7'h00 && rd_data[55:48] == 8'h00)
      else $error("unused threshold bits not zero");
   AST_RAMP_COUNT: assert property (@(posedge core_clk) disable iff (rst)
      (ce && ramp_state == RAMP_WAIT && ramp_rise && !ramp_ok) |=> ramp_counter == $past(snapshot_count) + 16'h1)
      else $error("ramp counter not snapshot plus one");
   AST_FIRST_ONLY: assert property (@(posedge core_clk) disable iff (rst)
      (ramp_state == RAMP_HELD) |=> ramp_state == RAMP_HELD && $stable(ramp_counter) || $past(ramp_ok))
      else $error("later ramp recorded");
   AST_RAMP_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      (ce && ramp_ok) |=> ramp_counter == 16'h0 && vin_mem[0] == 8'h00) else $error("ramp record not cleared");
   AST_RAMP_READ: assert property (@(posedge core_clk) disable iff (rst)
      (ce && rd_ok && is_ramp) |=> rd_len == `LEN_RAMP_RECORD && rd_data[15:0] == $past(ramp_counter))
      else $error("ramp block wrong");
   AST_RAMP_BOUND: assert property (@(posedge core_clk) disable iff (rst)
      (ramp_state == RAMP_REC) |-> ramp_idx < 4'(`RAMP_PAIRS)) else $error("too many ramp pairs");
   AST_SEL_SRC: assert property (@(posedge core_clk) disable iff (rst)
      (ce && wr_sel_ok) |=> temp_primary == ($past(wr_data[0]) ? temp_external : temp_internal))
      else $error("primary temperature source wrong");
   AST_VIN_READ: assert property (@(posedge core_clk) disable iff (rst)
      (ce && rd_ok && is_vin) |=> rd_data[31:0] == $past({vin_on_offset, vin_off_offset}))
      else $error("Vin offsets wrong");
   AST_LOG_START: assert property (@(posedge core_clk) disable iff (rst)
      seq_first_fall |=> seq_log_armed) else $error("status log did not start");
   AST_LOG_READ: assert property (@(posedge core_clk) disable iff (rst)
      (ce && rd_ok && is_status) |=> rd_len == `LEN_STATUS_LOG && rd_data[255:240] == $past(log_mem[15]))
      else $error("status block wrong");

   // Checks on trims, refusals, sensor outputs, sharing readback, ramp pairs and logging steps
   sequence seq_log_tick;
      ce && log_tick;
   endsequence
   sequence seq_log_word;
      log_mem[$past(log_slot)] == $past(status_word);
   endsequence

   AST_VOUT_READ: assert property (@(posedge core_clk) disable iff (rst)
      (ce && rd_ok && is_vout) |=> rd_len == `LEN_VOUT_TRIM && rd_data[15:0] == $past(vout_trim))
      else $error("Vout trim word wrong");
   AST_RO_REFUSE: assert property (@(posedge core_clk) disable iff (rst)
      (ce && wr_cmd && is_vin) |=> cmd_error && !rd_valid) else $error("read-only write accepted");
   AST_SEC_SRC: assert property (@(posedge core_clk) disable iff (rst)
      (ce && wr_sel_ok) |=> temp_secondary == ($past(wr_data[0]) ? temp_internal : temp_external))
      else $error("secondary temperature source wrong");
   AST_EN_READ: assert property (@(posedge core_clk) disable iff (rst)
      (ce && rd_ok && is_thr) |=> rd_data[56] == $past(share_enable) && rd_data[47:0] == $past(share_threshold))
      else $error("threshold readback wrong");
   AST_THR_LEN: assert property (@(posedge core_clk) disable iff (rst)
      (ce && wr_cmd && is_thr && wr_len != `LEN_SHARE_THRESHOLD) |=> cmd_error && $stable(share_threshold))
      else $error("short threshold write accepted");
   AST_PAIR_STORE: assert property (@(posedge core_clk) disable iff (rst)
      (ce && ramp_take && ramp_idx == 4'h0) |=> {vout_mem[0], vin_mem[0]} == $past({vout_sample, vin_sample}))
      else $error("first ramp pair not stored");
   AST_LOG_STEP: assert property (@(posedge core_clk) disable iff (rst)
      seq_log_tick |=> seq_log_word) else $error("status word not captured");
   AST_LOG_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      (log_state == LOG_DONE) |=> $stable(log_pack)) else $error("status log changed after sixteen words");
   AST_LOG_SPAN: assert property (@(posedge core_clk) disable iff (rst)
      (log_state == LOG_RUN) |-> log_timer < LOG_INTERVAL_CYCLES) else $error("capture interval overrun");

endmodule : mfr_command_logging_bank

// ===== rtl/mfr_consts.svh
// Command codes, lengths, field positions, reset values and timing counts of the logging bank
// Overview of operation
// - Four-byte ASCII write enters ROM mode
// - Eight-byte threshold block, 48-bit threshold field
// - Bit 56 enables active current sharing
// - Fifteen Vin/Vout pairs, spacing scaled to ramp
// - Ramp block: counter, then Vin/Vout byte pairs
// - Counter stores last snapshot count plus one
// - Only first ramp per power cycle recorded
// - Ramp record cleared after successful ramp-up
// - Select bit 0: internal or external sensor
// - Read-only Vin offsets: on high, off low
// - Vout trim monitor read as signed word
// - Status block holds sixteen 16-bit words
// - Log status every 8 s for 128 s
// - Primary temperature selected, secondary the other
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH

// Command codes
`define CMD_ROM_MODE        8'hd9
`define CMD_SHARE_THRESHOLD 8'hda
`define CMD_RAMP_RECORD     8'hdb
`define CMD_TEMP_SELECT     8'hdc
`define CMD_VIN_OFFSETS     8'hdd
`define CMD_VOUT_TRIM       8'hde
`define CMD_STATUS_LOG      8'hdf

// Transfer lengths in bytes
`define LEN_ROM_MODE        6'h04
`define LEN_SHARE_THRESHOLD 6'h08
`define LEN_RAMP_RECORD     6'h20
`define LEN_TEMP_SELECT     6'h01
`define LEN_VIN_OFFSETS     6'h04
`define LEN_VOUT_TRIM       6'h02
`define LEN_STATUS_LOG      6'h20

// Field positions
`define THR_MSB             47
`define THR_ENABLE_BIT      56
`define SEL_SOURCE_BIT      0

// Entry counts
`define RAMP_PAIRS          15
`define LOG_WORDS           16

// Reset values
`define THR_RESET           48'h000000000000
`define SEL_RESET           1'h0

// Timing
`define CLK_HZ              50000000
`define LOG_INTERVAL_S      8
`define LOG_SPAN_S          128
`define LOG_INTERVAL_CYCLES (`LOG_INTERVAL_S * `CLK_HZ)

`endif

// ===== rtl/mfr_pkg.sv
// Types shared by the logging bank
package mfr_pkg;

   // Ramp recorder states, Gray along wait, record, held
   typedef enum logic [1:0] {
      RAMP_WAIT = 2'h0,
      RAMP_REC  = 2'h1,
      RAMP_HELD = 2'h3
   } ramp_state_type;

   // Status logger states, Gray along idle, run, done
   typedef enum logic [1:0] {
      LOG_IDLE = 2'h0,
      LOG_RUN  = 2'h1,
      LOG_DONE = 2'h3
   } log_state_type;

   typedef logic [7:0]  byte_type;
   typedef logic [15:0] word_type;

endpackage : mfr_pkg

// ===== verif/mfr_command_logging_bank_test.sv
// Self-checking bench for the manufacturer command bank
`timescale 1ns/1ns
`include "mfr_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end
module mfr_command_logging_bank_test import mfr_pkg::*;;
   logic         core_clk, rst, ce, ramp_active, ramp_ok;   // Clock, reset and ramp controls
   logic         cmd_valid, cmd_write, rd_valid, cmd_error;  // Command port strobes
   logic [7:0]   cmd_code, vin_sample, vout_sample;         // Code and samples
   logic [5:0]   wr_len, rd_len;                            // Byte counts
   logic [255:0] wr_data, rd_data, r;                       // Payloads
   logic [31:0]  ramp_cycles;                               // Ramp duration
   word_type     snapshot_count, status_word, temp_internal, temp_external;
   word_type     vin_on_offset, vin_off_offset, vout_trim, temp_primary, temp_secondary;
   logic [47:0]  share_threshold;                           // Threshold output
   logic         share_enable, rom_mode, ok, err;           // Status outputs and answer flags
   int           num_errors, n_checks, cycles;              // Counters

   mfr_command_logging_bank #(.LOG_INTERVAL_CYCLES(32'd20)) mfr_command_logging_bank_inst (
      .core_clk(core_clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .wr_len(wr_len), .wr_data(wr_data), .ramp_active(ramp_active),
      .ramp_ok(ramp_ok), .ramp_cycles(ramp_cycles), .snapshot_count(snapshot_count),
      .vin_sample(vin_sample), .vout_sample(vout_sample), .status_word(status_word),
      .temp_internal(temp_internal), .temp_external(temp_external), .vin_on_offset(vin_on_offset),
      .vin_off_offset(vin_off_offset), .vout_trim(vout_trim), .rd_valid(rd_valid), .rd_len(rd_len),
      .rd_data(rd_data), .cmd_error(cmd_error), .rom_mode(rom_mode), .share_threshold(share_threshold),
      .share_enable(share_enable), .temp_primary(temp_primary), .temp_secondary(temp_secondary));

   mfr_host_model mfr_host_model_inst (
      .core_clk(core_clk), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_error(cmd_error),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .wr_len(wr_len), .wr_data(wr_data));

   // Clock of 20 ns period
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Counts and verdict, then stop
   task automatic results;
      $display("Checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   // Hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         results();
      end
   end

   // Shorthand for one host transfer
   task automatic x(input logic wr, input logic [7:0] c, input logic [5:0] l, input logic [255:0] d);
      mfr_host_model_inst.xfer(wr, c, l, d, r, ok, err);
   endtask : x

   // Reset values and sensor default
   task automatic t_reset;
      x(1'b0, `CMD_SHARE_THRESHOLD, 6'h00, '0);
      `CHK(r, 256'h0)
      `CHK(ok, 1'b1)
      `CHK(rd_len, `LEN_SHARE_THRESHOLD)
      `CHK(temp_primary, 16'h1111)
   endtask : t_reset

   // Threshold field, enable bit, unused bits and length refusal
   task automatic t_share;
      x(1'b1, `CMD_SHARE_THRESHOLD, 6'h08, 256'hffffffffffffffff);
      `CHK(share_threshold, 48'hffffffffffff)
      `CHK(share_enable, 1'b1)
      x(1'b0, `CMD_SHARE_THRESHOLD, 6'h00, '0);
      `CHK(r, 256'h0100ffffffffffff)
      x(1'b1, `CMD_SHARE_THRESHOLD, 6'h08, 256'h00fe123456789abc);
      `CHK(share_enable, 1'b0)
      `CHK(share_threshold, 48'h123456789abc)
      x(1'b1, `CMD_SHARE_THRESHOLD, 6'h07, 256'h0);
      `CHK(err, 1'b1)
      ce <= 1'b0;
      x(1'b1, `CMD_SHARE_THRESHOLD, 6'h08, 256'h0);
      ce <= 1'b1;
      `CHK(share_threshold, 48'h123456789abc)
   endtask : t_share

   // Sensor selection both ways
   task automatic t_select;
      x(1'b1, `CMD_TEMP_SELECT, 6'h01, 256'hff);
      `CHK(temp_primary, 16'h2222)
      `CHK(temp_secondary, 16'h1111)
      x(1'b0, `CMD_TEMP_SELECT, 6'h00, '0);
      `CHK(r, 256'h1)
      x(1'b1, `CMD_TEMP_SELECT, 6'h01, 256'h0);
      `CHK(temp_secondary, 16'h2222)
   endtask : t_select

   // Read-only trims
   task automatic t_trims;
      x(1'b0, `CMD_VIN_OFFSETS, 6'h00, '0);
      `CHK(r, 256'h33334444)
      x(1'b0, `CMD_VOUT_TRIM, 6'h00, '0);
      `CHK(r, 256'h8001)
      `CHK(rd_len, `LEN_VOUT_TRIM)
      x(1'b1, `CMD_VIN_OFFSETS, 6'h04, 256'h1);
      `CHK(err, 1'b1)
      `CHK(ok, 1'b0)
   endtask : t_trims

   // Ramp recorder, status log start, second ramp and clear
   task automatic t_ramp;
      ramp_active <= 1'b1;
      repeat (6) @(posedge core_clk);
      x(1'b0, `CMD_RAMP_RECORD, 6'h00, '0);
      `CHK(r[255:240], 16'h0)
      `CHK(r[31:16], 16'ha55a)
      `CHK(r[63:48], 16'ha55a)
      `CHK(r[79:64], 16'h0)
      repeat (35) @(posedge core_clk);
      ramp_active <= 1'b0;
      repeat (3) @(posedge core_clk);
      x(1'b0, `CMD_RAMP_RECORD, 6'h00, '0);
      `CHK(r[15:0], 16'h0042)
      `CHK(r[255:16], {15{16'ha55a}})
      x(1'b0, `CMD_STATUS_LOG, 6'h00, '0);
      `CHK(r[15:0], 16'hbeef)
      `CHK(r[255:240], 16'h0)
      vin_sample <= 8'h11;
      ramp_active <= 1'b1;
      repeat (40) @(posedge core_clk);
      ramp_active <= 1'b0;
      repeat (400) @(posedge core_clk);
      status_word <= 16'hcafe;
      x(1'b0, `CMD_RAMP_RECORD, 6'h00, '0);
      `CHK(r[255:16], {15{16'ha55a}})
      x(1'b0, `CMD_STATUS_LOG, 6'h00, '0);
      `CHK(r, {16{16'hbeef}})
      repeat (40) @(posedge core_clk);
      x(1'b0, `CMD_STATUS_LOG, 6'h00, '0);
      `CHK(r[255:240], 16'hbeef)
      ramp_ok <= 1'b1;
      @(posedge core_clk);
      ramp_ok <= 1'b0;
      x(1'b0, `CMD_RAMP_RECORD, 6'h00, '0);
      `CHK(r, 256'h0)
   endtask : t_ramp

   // ROM entry: non-ASCII refused, read refused, valid entry
   task automatic t_rom;
      x(1'b1, `CMD_ROM_MODE, 6'h04, 256'h544f4fc2);
      `CHK(err, 1'b1)
      `CHK(rom_mode, 1'b0)
      x(1'b0, `CMD_ROM_MODE, 6'h00, '0);
      `CHK(err, 1'b1)
      mfr_host_model_inst.enter_rom(err);
      `CHK(rom_mode, 1'b1)
   endtask : t_rom

   // Main sequence
   initial begin
      num_errors = 0;
      n_checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      ramp_active = 1'b0;
      ramp_ok = 1'b0;
      ramp_cycles = 32'd30;
      snapshot_count = 16'h0041;
      vin_sample = 8'h5a;
      vout_sample = 8'ha5;
      status_word = 16'hbeef;
      temp_internal = 16'h1111;
      temp_external = 16'h2222;
      vin_on_offset = 16'h3333;
      vin_off_offset = 16'h4444;
      vout_trim = 16'h8001;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_share();
      t_select();
      t_trims();
      @(posedge core_clk);
      t_ramp();
      t_rom();
      results();
   end
endmodule : mfr_command_logging_bank_test

// ===== verif/mfr_host_model.sv
// Host side model that issues decoded command transfers to the bank
`timescale 1ns/1ns
module mfr_host_model (
   input  wire logic         core_clk,  // Bank clock
   input  wire logic         rd_valid,  // Read answer strobe
   input  wire logic [255:0] rd_data,   // Read answer payload
   input  wire logic         cmd_error, // Refusal strobe
   output logic              cmd_valid, // Command strobe
   output logic              cmd_write, // Write flag
   output logic [7:0]        cmd_code,  // Command code
   output logic [5:0]        wr_len,    // Write byte count
   output logic [255:0]      wr_data    // Write payload
);
   // Idle bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      wr_len    = 6'h00;
      wr_data   = '0;
   end

   // One transfer; answer taken the cycle after acceptance
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [5:0] len,
                       input logic [255:0] data, output logic [255:0] rdat, output logic ok, output logic err);
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_code  <= code;
      wr_len    <= len;
      wr_data   <= data;
      @(posedge core_clk);
      // Released lines show no stale value
      cmd_valid <= 1'b0;
      cmd_code  <= ~code;
      wr_len    <= ~len;
      wr_data   <= ~data;
      // Answer stands for the cycle after acceptance; read it at the edge that ends it
      @(posedge core_clk);
      rdat = rd_data;
      ok   = rd_valid;
      err  = cmd_error;
   endtask : xfer

   task automatic enter_rom(output logic err);
      logic [255:0] rdat;
      logic         ok;
      xfer(1'b1, 8'hd9, 6'h04, 256'h544f4f42, rdat, ok, err);
   endtask : enter_rom
endmodule : mfr_host_model
